// ===== tb/info_bank_props.sv
// Assertions for the redundant module information bank.
// Assumes a bind onto redundant_info_bank; sees its ports only.
`timescale 1ns/1ns
module info_bank_props #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd(logic [7:0] a, logic [7:0] b);
        s_req ##0 (!wb_we_i && (wb_adr_i == a || wb_adr_i == b));
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_WR_ZERO: assert property (s_req ##0 wb_we_i |=> wb_dat_o == 32'h0)
        else $error("write returned data");
    AST_STATE_MAX: assert property (s_rd(8'h10, 8'h20) |=> wb_dat_o <= 32'h5)
        else $error("state code above 5");
    AST_FLAG_BIT: assert property (s_rd(8'h0c, 8'h1c) |=> wb_dat_o[31:1] == 31'h0)
        else $error("health flag wider than one bit");
    AST_LOC_W: assert property (s_rd(8'h04, 8'h14) |=> wb_dat_o[31:16] == 16'h0)
        else $error("chassis value too wide");
    AST_HOLE: assert property (s_req ##0 (!wb_we_i && wb_adr_i > 8'h28) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_RST_QUIET: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
        else $error("outputs busy after reset");
endmodule

// ===== tb/tb.sv
// Self-checking bench for the redundant module information bank.
// Assumes the package, the bank and its checker compile first.
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    logic [15:0] a_ch = 16'h0, a_sl = 16'h0, b_ch = 16'h0, b_sl = 16'h0;
    logic a_ok = 1'b0, b_ok = 1'b0, b_act = 1'b0;
    logic [2:0] a_st = 3'h0, b_st = 3'h0;
    logic [31:0] d;
    int err_total = 0;
    int tests_run = 0;

    redundant_info_bank i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_a_chassis_i(a_ch), .mod_a_slot_i(a_sl),
        .mod_a_healthy_i(a_ok), .mod_a_state_i(a_st), .mod_b_chassis_i(b_ch),
        .mod_b_slot_i(b_sl), .mod_b_healthy_i(b_ok), .mod_b_state_i(b_st),
        .b_is_active_i(b_act), .irq_o(irq_o)
    );

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the request until ack is sampled; no fixed latency assumed
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= wd;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        d = wb_dat_o;
        chk("ack", {31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
        bus(1'b0, adr, 32'h0);
        chk(what, d, exp);
    endtask

    // Pin path needs five edges; eight leaves margin
    task automatic settle;
        repeat (8) @(posedge clk_i);
    endtask

    // Eight expected channel values, channel 1 in the top 16 bits
    task automatic bank(input logic [127:0] e);
        for (int i = 0; i < 8; i++)
            rd(8'(4 * i + 4), {16'h0, e[127 - 16 * i -: 16]}, "channel");
    endtask

    task automatic t_bank;
        @(posedge clk_i);
        a_ch <= 16'h0011;
        a_sl <= 16'h0003;
        a_ok <= 1'b1;
        a_st <= info_bank_pkg::ST_ACTIVE;
        b_ch <= 16'h0012;
        b_sl <= 16'h0007;
        b_st <= info_bank_pkg::ST_STANDBY;
        settle();
        bank({16'h11, 16'h3, 16'h1, 16'h3, 16'h12, 16'h7, 16'h0, 16'h2});
        @(posedge clk_i);
        b_act <= 1'b1;
        settle();
        bank({16'h12, 16'h7, 16'h0, 16'h2, 16'h11, 16'h3, 16'h1, 16'h3});
        $display("bank test done");
    endtask

    task automatic t_states;
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk_i);
            b_st <= 3'(c);
            a_st <= 3'(7 - c);
            settle();
            rd(8'h10, (c > 5) ? 32'h0 : 32'(c), "active state");
            rd(8'h20, (7 - c > 5) ? 32'h0 : 32'(7 - c), "standby state");
        end
        $display("state test done");
    endtask

    task automatic t_ro;
        for (int i = 0; i < 8; i++)
            bus(1'b1, 8'(4 * i + 4), 32'hffff_ffff);
        bus(1'b1, 8'h30, 32'h5a5a_5a5a);
        rd(8'h30, 32'h0, "hole");
        bank({16'h12, 16'h7, 16'h0, 16'h0, 16'h11, 16'h3, 16'h1, 16'h0});
        $display("read-only test done");
    endtask

    task automatic t_irq;
        rd(info_bank_pkg::OFS_IRQ_MASK, 32'h0, "mask reset");
        bus(1'b0, info_bank_pkg::OFS_IRQ_STATUS, 32'h0);
        bus(1'b1, info_bank_pkg::OFS_IRQ_MASK, 32'h1);
        @(posedge clk_i);
        b_act <= 1'b0;
        settle();
        chk("irq set", {31'h0, irq_o}, 32'h1);
        bus(1'b0, info_bank_pkg::OFS_IRQ_STATUS, 32'h0);
        chk("changeover", d & 32'h1, 32'h1);
        @(posedge clk_i);
        chk("irq clear", {31'h0, irq_o}, 32'h0);
        bus(1'b1, info_bank_pkg::OFS_IRQ_MASK, 32'h0);
        @(posedge clk_i);
        b_act <= 1'b1;
        settle();
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        bus(1'b0, info_bank_pkg::OFS_IRQ_STATUS, 32'h0);
        chk("sticky", d & 32'h1, 32'h1);
        $display("irq test done");
    endtask

    // Health falls, a bad code and leaving steady state, all in one edge
    task automatic t_events;
        @(posedge clk_i);
        a_st <= info_bank_pkg::ST_STANDBY;
        b_st <= info_bank_pkg::ST_ACTIVE;
        b_ok <= 1'b1;
        settle();
        bus(1'b0, info_bank_pkg::OFS_IRQ_STATUS, 32'h0);
        rd(info_bank_pkg::OFS_IRQ_STATUS, 32'h0, "steady status");
        bus(1'b1, info_bank_pkg::OFS_IRQ_MASK, 32'h2);
        @(posedge clk_i);
        a_ok <= 1'b0;
        b_ok <= 1'b0;
        b_st <= 3'h6;
        settle();
        chk("fault irq", {31'h0, irq_o}, 32'h1);
        rd(info_bank_pkg::OFS_IRQ_STATUS, 32'h1e, "events");
        chk("irq after read", {31'h0, irq_o}, 32'h0);
        rd(info_bank_pkg::OFS_IRQ_STATUS, 32'h8, "set wins");
        $display("event test done");
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_bank();
        t_states();
        t_ro();
        t_irq();
        t_events();
        end_sim();
    end

    // Whole run is near 320 cycles
    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        $display("Watchdog expired");
        end_sim();
    end
endmodule

bind redundant_info_bank info_bank_props #(.ADR_W(ADR_W)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o)
);

// ===== verilog/info_bank_pkg.sv
// Constants for the redundant module information bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package info_bank_pkg;

    // Channel and report widths
    localparam int LOC_W = 16;
    localparam int STATE_W = 3;
    localparam int CHAN_W = 16;
    localparam int BUS_W = 32;
    localparam int ADR_W = 8;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_ACT_CHASSIS = 8'h04;
    localparam logic [7:0] OFS_ACT_SLOT = 8'h08;
    localparam logic [7:0] OFS_ACT_HEALTH = 8'h0c;
    localparam logic [7:0] OFS_ACT_STATE = 8'h10;
    localparam logic [7:0] OFS_STB_CHASSIS = 8'h14;
    localparam logic [7:0] OFS_STB_SLOT = 8'h18;
    localparam logic [7:0] OFS_STB_HEALTH = 8'h1c;
    localparam logic [7:0] OFS_STB_STATE = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

    // Operating state codes
    localparam logic [2:0] ST_UNKNOWN = 3'h0;
    localparam logic [2:0] ST_CONFIG = 3'h1;
    localparam logic [2:0] ST_STANDBY = 3'h2;
    localparam logic [2:0] ST_ACTIVE = 3'h3;
    localparam logic [2:0] ST_MAINTAIN = 3'h4;
    localparam logic [2:0] ST_SHUTDOWN = 3'h5;

    // Health flag values
    localparam logic HEALTH_OK = 1'b1;
    localparam logic HEALTH_FAULT = 1'b0;

    // Event bit positions in status and mask
    localparam int EV_N = 5;
    localparam int EV_CHANGEOVER = 0;
    localparam int EV_ACT_FAULT = 1;
    localparam int EV_STB_FAULT = 2;
    localparam int EV_BAD_STATE = 3;
    localparam int EV_UNSTEADY = 4;

    // Reset values
    localparam logic [LOC_W-1:0] RST_LOC = 16'h0000;
    localparam logic RST_HEALTH = 1'b0;
    localparam logic [EV_N-1:0] RST_STATUS = 5'h00;
    localparam logic [EV_N-1:0] RST_MASK = 5'h00;
    localparam logic [BUS_W-1:0] RST_DAT = 32'h0000_0000;
    localparam logic RST_SEL_B = 1'b0;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

// ===== verilog/redundant_info_bank.sv
// Read-only information bank for a redundant monitor module pair.
// Assumes module reports and the active selector arrive on pins,
// and software reads the bank over classic Wishbone.
//
// Function
// - Channel 1 reports the chassis number of the active module.
// - Channel 2 reports the slot number of the active module.
// - On changeover the active and standby locations swap in the same edge.
// - Channel 3 holds the active health flag, 1 normal and 0 fault.
// - Channel 4 encodes the active state as 0 to 5 in the fixed code set.
// - The active state reads 3 in steady operation, other codes only in transit.
// - Codes above 5 are never produced and a reader treats them as invalid.
// - Channel 5 reports the chassis number of the standby module.
// - Channel 6 reports the slot number of the standby module.
// - Channel 7 holds the standby health flag, 1 normal and 0 fault.
// - Channel 8 reports the current state of the standby module.
// - The standby state uses the same codes and reads 2 in steady operation.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module redundant_info_bank #(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] mod_a_chassis_i,
    input wire logic [15:0] mod_a_slot_i,
    input wire logic mod_a_healthy_i,
    input wire logic [2:0] mod_a_state_i,
    input wire logic [15:0] mod_b_chassis_i,
    input wire logic [15:0] mod_b_slot_i,
    input wire logic mod_b_healthy_i,
    input wire logic [2:0] mod_b_state_i,
    input wire logic b_is_active_i,
    output logic irq_o
);

    localparam int REP_W = 2 * info_bank_pkg::LOC_W + 1 + info_bank_pkg::STATE_W;

    typedef struct packed {
        info_bank_pkg::bus_state_t bus;
        logic ack;
        logic [31:0] dat;
        logic sel_b;
        logic [15:0] act_chassis;
        logic [15:0] act_slot;
        logic act_health;
        logic [2:0] act_state;
        logic [15:0] stb_chassis;
        logic [15:0] stb_slot;
        logic stb_health;
        logic [2:0] stb_state;
        logic unsteady;
        logic [info_bank_pkg::EV_N-1:0] status;
        logic [info_bank_pkg::EV_N-1:0] mask;
        logic irq;
    } bank_t;

    bank_t r_q;
    bank_t r_d;

    logic [REP_W-1:0] rep_a;
    logic [REP_W-1:0] rep_b;
    logic [0:0] sel_sync;

    // Out-of-range codes map to unknown
    function automatic logic [2:0] clean_state(input logic [2:0] s);
        if (s > info_bank_pkg::ST_SHUTDOWN)
        begin
            return info_bank_pkg::ST_UNKNOWN;
        end
        return s;
    endfunction

    function automatic logic bad_state(input logic [2:0] s);
        return s > info_bank_pkg::ST_SHUTDOWN;
    endfunction

    // Only a fall is an event; a recovery raises nothing
    function automatic logic health_fell(input logic q, input logic n);
        return q == info_bank_pkg::HEALTH_OK && n == info_bank_pkg::HEALTH_FAULT;
    endfunction

    // Steady pair is active 3 and standby 2
    function automatic logic off_steady(input logic [2:0] a, input logic [2:0] s);
        return (a != info_bank_pkg::ST_ACTIVE) || (s != info_bank_pkg::ST_STANDBY);
    endfunction

    // Field pick-out of a report word, same layout for both modules
    function automatic logic [15:0] rep_chassis(input logic [REP_W-1:0] r);
        return r[REP_W-1 -: 16];
    endfunction

    function automatic logic [15:0] rep_slot(input logic [REP_W-1:0] r);
        return r[REP_W-17 -: 16];
    endfunction

    function automatic logic rep_health(input logic [REP_W-1:0] r);
        return r[info_bank_pkg::STATE_W];
    endfunction

    function automatic logic [2:0] rep_state(input logic [REP_W-1:0] r);
        return r[info_bank_pkg::STATE_W-1:0];
    endfunction

    // Word read from a bank address, zero for holes
    function automatic logic [31:0] read_word(input bank_t b, input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            info_bank_pkg::OFS_ACT_CHASSIS: w = {16'h0000, b.act_chassis};
            info_bank_pkg::OFS_ACT_SLOT: w = {16'h0000, b.act_slot};
            info_bank_pkg::OFS_ACT_HEALTH: w = {31'h0000_0000, b.act_health};
            info_bank_pkg::OFS_ACT_STATE: w = {29'h0000_0000, b.act_state};
            info_bank_pkg::OFS_STB_CHASSIS: w = {16'h0000, b.stb_chassis};
            info_bank_pkg::OFS_STB_SLOT: w = {16'h0000, b.stb_slot};
            info_bank_pkg::OFS_STB_HEALTH: w = {31'h0000_0000, b.stb_health};
            info_bank_pkg::OFS_STB_STATE: w = {29'h0000_0000, b.stb_state};
            info_bank_pkg::OFS_IRQ_STATUS: w = {27'h0000_0000, b.status};
            info_bank_pkg::OFS_IRQ_MASK: w = {27'h0000_0000, b.mask};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Each report is filtered on its own; the selector has its own path
    report_sync #(
        .W(REP_W),
        .RST_VAL('0)
    ) u_sync_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i({mod_a_chassis_i, mod_a_slot_i, mod_a_healthy_i, mod_a_state_i}),
        .stable_o(rep_a)
    );

    report_sync #(
        .W(REP_W),
        .RST_VAL('0)
    ) u_sync_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i({mod_b_chassis_i, mod_b_slot_i, mod_b_healthy_i, mod_b_state_i}),
        .stable_o(rep_b)
    );

    report_sync #(
        .W(1),
        .RST_VAL(info_bank_pkg::RST_SEL_B)
    ) u_sync_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(b_is_active_i),
        .stable_o(sel_sync)
    );

    logic [REP_W-1:0] rep_act;
    logic [REP_W-1:0] rep_stb;
    logic [2:0] raw_act_state;
    logic [2:0] raw_stb_state;
    logic [7:0] adr8;
    logic req;
    logic rd_status;
    logic [info_bank_pkg::EV_N-1:0] ev;
    logic unsteady_now;

    always_comb
    begin
        r_d = r_q;
        ev = '0;
        adr8 = 8'(wb_adr_i);
        req = wb_cyc_i && wb_stb_i;
        rd_status = 1'b0;

        // One selector picks both halves, so the pair can never name one module twice
        rep_act = sel_sync[0] ? rep_b : rep_a;
        rep_stb = sel_sync[0] ? rep_a : rep_b;
        raw_act_state = rep_state(rep_act);
        raw_stb_state = rep_state(rep_stb);

        r_d.sel_b = sel_sync[0];
        r_d.act_chassis = rep_chassis(rep_act);
        r_d.act_slot = rep_slot(rep_act);
        r_d.act_health = rep_health(rep_act);
        r_d.act_state = clean_state(raw_act_state);
        r_d.stb_chassis = rep_chassis(rep_stb);
        r_d.stb_slot = rep_slot(rep_stb);
        r_d.stb_health = rep_health(rep_stb);
        r_d.stb_state = clean_state(raw_stb_state);

        // Events
        if (sel_sync[0] != r_q.sel_b)
        begin
            ev[info_bank_pkg::EV_CHANGEOVER] = 1'b1;
        end
        if (health_fell(r_q.act_health, r_d.act_health))
        begin
            ev[info_bank_pkg::EV_ACT_FAULT] = 1'b1;
        end
        if (health_fell(r_q.stb_health, r_d.stb_health))
        begin
            ev[info_bank_pkg::EV_STB_FAULT] = 1'b1;
        end
        if (bad_state(raw_act_state) || bad_state(raw_stb_state))
        begin
            ev[info_bank_pkg::EV_BAD_STATE] = 1'b1;
        end
        // Off-steady codes are legal in transit, so only flag the entry
        unsteady_now = off_steady(r_d.act_state, r_d.stb_state);
        r_d.unsteady = unsteady_now;
        if (unsteady_now && !r_q.unsteady)
        begin
            ev[info_bank_pkg::EV_UNSTEADY] = 1'b1;
        end

        // Bus slave: ack one cycle after the request, dropped the next
        case (r_q.bus)
            info_bank_pkg::BUS_IDLE:
            begin
                r_d.ack = 1'b0;
                if (req)
                begin
                    r_d.bus = info_bank_pkg::BUS_ACK;
                    r_d.ack = 1'b1;
                    if (wb_we_i)
                    begin
                        r_d.dat = info_bank_pkg::RST_DAT;
                        // Only the mask takes writes; channel writes are dropped
                        if (adr8 == info_bank_pkg::OFS_IRQ_MASK && wb_sel_i[0])
                        begin
                            r_d.mask = wb_dat_i[info_bank_pkg::EV_N-1:0];
                        end
                    end
                    else
                    begin
                        r_d.dat = read_word(r_q, adr8);
                        rd_status = (adr8 == info_bank_pkg::OFS_IRQ_STATUS);
                    end
                end
            end
            info_bank_pkg::BUS_ACK:
            begin
                r_d.bus = info_bank_pkg::BUS_IDLE;
                r_d.ack = 1'b0;
            end
            default:
            begin
                r_d.bus = info_bank_pkg::BUS_IDLE;
                r_d.ack = 1'b0;
            end
        endcase

        // Read clears what was returned; a new event in that cycle survives
        r_d.status = (rd_status ? '0 : r_q.status) | ev;
        r_d.irq = |(r_d.status & r_d.mask);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r_q.bus <= info_bank_pkg::BUS_IDLE;
            r_q.ack <= 1'b0;
            r_q.dat <= info_bank_pkg::RST_DAT;
            r_q.sel_b <= info_bank_pkg::RST_SEL_B;
            r_q.act_chassis <= info_bank_pkg::RST_LOC;
            r_q.act_slot <= info_bank_pkg::RST_LOC;
            r_q.act_health <= info_bank_pkg::RST_HEALTH;
            r_q.act_state <= info_bank_pkg::ST_UNKNOWN;
            r_q.stb_chassis <= info_bank_pkg::RST_LOC;
            r_q.stb_slot <= info_bank_pkg::RST_LOC;
            r_q.stb_health <= info_bank_pkg::RST_HEALTH;
            r_q.stb_state <= info_bank_pkg::ST_UNKNOWN;
            r_q.unsteady <= 1'b1;
            r_q.status <= info_bank_pkg::RST_STATUS;
            r_q.mask <= info_bank_pkg::RST_MASK;
            r_q.irq <= 1'b0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign wb_dat_o = r_q.dat;
    assign wb_ack_o = r_q.ack;
    assign irq_o = r_q.irq;

endmodule

// ===== verilog/report_sync.sv
// Two-flop synchroniser with a stability filter for one module report.
// Assumes the raw report comes from pins outside the clk_i domain.
`timescale 1ns/1ns
module report_sync #(
    parameter int W = 36,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] raw_i,
    output logic [W-1:0] stable_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
        logic [W-1:0] stable;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.meta = raw_i;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
        // Word is taken only when two samples agree, so no torn word passes
        if (s_q.sync == s_q.prev)
        begin
            s_d.stable = s_q.prev;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign stable_o = s_q.stable;

endmodule
